// *** verilog/dsw_pkg.sv ***
// constants for the drive status word encoder
package dsw_pkg;
   localparam int          DSW_WIDTH         = 16;
   localparam logic [15:0] DSW_RESET         = 16'h0000;
   localparam logic [15:0] DSW_FULL_SCALE    = 16'h4000;
   localparam int          BIT_CTRL_READY    = 0;
   localparam int          BIT_DRIVE_READY   = 1;
   localparam int          BIT_ENABLE        = 2;
   localparam int          BIT_TRIP          = 3;
   localparam int          BIT_ERROR         = 4;
   localparam int          BIT_RESERVED      = 5;
   localparam int          BIT_TRIPLOCK      = 6;
   localparam int          BIT_WARNING       = 7;
   localparam int          BIT_SPEED_EQ      = 8;
   localparam int          BIT_BUS_CTRL      = 9;
   localparam int          BIT_FREQ_OK       = 10;
   localparam int          BIT_IN_OPERATION  = 11;
   localparam int          BIT_OVERTEMP_STOP = 12;
   localparam int          BIT_VOLTAGE_EXC   = 13;
   localparam int          BIT_TORQUE_EXC    = 14;
   localparam int          BIT_TIMER_EXC     = 15;
endpackage : dsw_pkg

// *** verilog/dsw_encoder.sv ***
// drive status word encoder and output frequency word register
module dsw_encoder
   import dsw_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ctrl_ready_i,
   input  wire logic        drive_ready_i,
   input  wire logic        coast_i,
   input  wire logic        fault_trip_i,
   input  wire logic        trip_reset_i,
   input  wire logic        error_no_trip_i,
   input  wire logic        trip_locked_i,
   input  wire logic        warning_i,
   input  wire logic        local_stop_i,
   input  wire logic        local_site_i,
   input  wire logic        start_i,
   input  wire logic        overtemp_stop_i,
   input  wire logic        dc_volt_low_i,
   input  wire logic        dc_volt_high_i,
   input  wire logic        current_over_limit_i,
   input  wire logic        timer_over_full_i,
   input  wire logic        link_lost_i,
   input  wire logic        comm_fault_i,
   input  wire logic [15:0] speed_ref_i,
   input  wire logic [15:0] out_freq_i,
   input  wire logic [15:0] freq_low_limit_i,
   input  wire logic [15:0] freq_high_limit_i,
   output logic      [15:0] drive_status_word_o,
   output logic      [15:0] actual_output_frequency_value_o,
   output logic             tripped_o
);

   ////////////////////////////////////////////////////////////////////////
   // synchronisers: the condition inputs come from other logic domains
   logic [17:0] cond_meta_reg;
   logic [17:0] cond_reg;
   logic [17:0] cond_raw;
   assign cond_raw = {ctrl_ready_i, drive_ready_i, coast_i, fault_trip_i, trip_reset_i,
                      error_no_trip_i, trip_locked_i, warning_i, local_stop_i, local_site_i,
                      start_i, overtemp_stop_i, dc_volt_low_i, dc_volt_high_i,
                      current_over_limit_i, timer_over_full_i, link_lost_i, comm_fault_i};

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cond_meta_reg <= '0;
         cond_reg      <= '0;
      end else begin
         cond_meta_reg <= cond_raw;
         cond_reg      <= cond_meta_reg;
      end
   end

   wire s_ctrl_ready  = cond_reg[17];
   wire s_drive_ready = cond_reg[16];
   wire s_coast       = cond_reg[15];
   wire s_fault       = cond_reg[14];
   wire s_reset       = cond_reg[13];
   wire s_error       = cond_reg[12];
   wire s_locked      = cond_reg[11];
   wire s_warning     = cond_reg[10];
   wire s_local_stop  = cond_reg[9];
   wire s_local_site  = cond_reg[8];
   wire s_start       = cond_reg[7];
   wire s_overtemp    = cond_reg[6];
   wire s_volt_low    = cond_reg[5];
   wire s_volt_high   = cond_reg[4];
   wire s_cur_over    = cond_reg[3];
   wire s_timer_over  = cond_reg[2];
   wire s_link_lost   = cond_reg[1];
   wire s_comm_fault  = cond_reg[0];

   ////////////////////////////////////////////////////////////////////////
   // word samples: two stages, then a word is taken only when two synced
   // samples agree, so a word caught half changed never reaches the logic
   logic [15:0] ref_meta_reg,  ref_sync_reg,  ref_prev_reg,  ref_reg;
   logic [15:0] freq_meta_reg, freq_sync_reg, freq_prev_reg, freq_reg;
   logic [15:0] lo_meta_reg,   lo_sync_reg,   lo_prev_reg,   lo_reg;
   logic [15:0] hi_meta_reg,   hi_sync_reg,   hi_prev_reg,   hi_reg;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ref_meta_reg  <= 16'h0000;
         ref_sync_reg  <= 16'h0000;
         ref_prev_reg  <= 16'h0000;
         freq_meta_reg <= 16'h0000;
         freq_sync_reg <= 16'h0000;
         freq_prev_reg <= 16'h0000;
         lo_meta_reg   <= 16'h0000;
         lo_sync_reg   <= 16'h0000;
         lo_prev_reg   <= 16'h0000;
         hi_meta_reg   <= 16'h0000;
         hi_sync_reg   <= 16'h0000;
         hi_prev_reg   <= 16'h0000;
      end else begin
         ref_meta_reg  <= speed_ref_i;
         ref_sync_reg  <= ref_meta_reg;
         ref_prev_reg  <= ref_sync_reg;
         freq_meta_reg <= out_freq_i;
         freq_sync_reg <= freq_meta_reg;
         freq_prev_reg <= freq_sync_reg;
         lo_meta_reg   <= freq_low_limit_i;
         lo_sync_reg   <= lo_meta_reg;
         lo_prev_reg   <= lo_sync_reg;
         hi_meta_reg   <= freq_high_limit_i;
         hi_sync_reg   <= hi_meta_reg;
         hi_prev_reg   <= hi_sync_reg;
      end
   end

   // costs the words two more cycles of latency; the condition bits do not pay it
   wire ref_agree  = (ref_sync_reg == ref_prev_reg);
   wire freq_agree = (freq_sync_reg == freq_prev_reg);
   wire lo_agree   = (lo_sync_reg == lo_prev_reg);
   wire hi_agree   = (hi_sync_reg == hi_prev_reg);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ref_reg  <= 16'h0000;
         freq_reg <= 16'h0000;
         lo_reg   <= 16'h0000;
         hi_reg   <= 16'h0000;
      end else begin
         if (ref_agree) begin
            ref_reg <= ref_sync_reg;
         end
         if (freq_agree) begin
            freq_reg <= freq_sync_reg;
         end
         if (lo_agree) begin
            lo_reg <= lo_sync_reg;
         end
         if (hi_agree) begin
            hi_reg <= hi_sync_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trip latch: set wins over reset so a new fault is never lost
   logic trip_reg, trip_next, reset_d_reg;
   wire  reset_rise = s_reset & ~reset_d_reg;
   assign trip_next = s_fault ? 1'b1 : (reset_rise ? 1'b0 : trip_reg);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         trip_reg    <= 1'b0;
         reset_d_reg <= 1'b0;
      end else begin
         trip_reg    <= trip_next;
         reset_d_reg <= s_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // signed percentage words: 16384 is 100 percent, negatives two's complement
   function automatic logic signed [15:0] pct_word(input logic [15:0] raw);
      pct_word = signed'(raw);
   endfunction : pct_word

   wire signed [15:0] ref_s  = pct_word(ref_reg);
   wire signed [15:0] freq_s = pct_word(freq_reg);
   wire signed [15:0] lo_s   = pct_word(lo_reg);
   wire signed [15:0] hi_s   = pct_word(hi_reg);
   wire [15:0] freq_abs = freq_s[15] ? 16'(-freq_s) : 16'(freq_s);

   ////////////////////////////////////////////////////////////////////////
   // status word assembly
   logic [15:0] word_raw;
   logic [15:0] dsw_next;
   wire         word_kill = s_link_lost | s_comm_fault;

   always_comb begin
      word_raw                    = DSW_RESET;
      word_raw[BIT_CTRL_READY]    = s_ctrl_ready & ~trip_reg;
      word_raw[BIT_DRIVE_READY]   = s_drive_ready;
      word_raw[BIT_ENABLE]        = ~s_coast;
      word_raw[BIT_TRIP]          = trip_reg;
      word_raw[BIT_ERROR]         = s_error & ~trip_reg;
      word_raw[BIT_RESERVED]      = 1'b0;
      word_raw[BIT_TRIPLOCK]      = trip_reg & s_locked;
      word_raw[BIT_WARNING]       = s_warning;
      word_raw[BIT_SPEED_EQ]      = (freq_s == ref_s);
      word_raw[BIT_BUS_CTRL]      = ~(s_local_stop | s_local_site);
      word_raw[BIT_FREQ_OK]       = (freq_abs > lo_s) && (freq_abs < hi_s);
      word_raw[BIT_IN_OPERATION]  = s_start | (freq_s != 16'sh0000);
      word_raw[BIT_OVERTEMP_STOP] = s_overtemp & ~trip_reg;
      word_raw[BIT_VOLTAGE_EXC]   = s_volt_low | s_volt_high;
      word_raw[BIT_TORQUE_EXC]    = s_cur_over;
      word_raw[BIT_TIMER_EXC]     = s_timer_over;
      dsw_next                    = word_kill ? DSW_RESET : word_raw;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         drive_status_word_o             <= DSW_RESET;
         actual_output_frequency_value_o <= 16'h0000;
      end else begin
         drive_status_word_o             <= dsw_next;
         actual_output_frequency_value_o <= freq_reg;
      end
   end

   assign tripped_o = trip_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_kill_zero;
      @(posedge core_clk_i) disable iff (rst_i)
      word_kill |=> (drive_status_word_o == 16'h0000);
   endproperty
   a_kill_zero: assert property (p_kill_zero) else $error("word not zero on link loss");

   property p_reserved;
      @(posedge core_clk_i) disable iff (rst_i)
      drive_status_word_o[BIT_RESERVED] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_trip_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      (trip_reg && !reset_rise) |=> trip_reg;
   endproperty
   a_trip_hold: assert property (p_trip_hold) else $error("trip dropped without reset");

   property p_fault_trip;
      @(posedge core_clk_i) disable iff (rst_i)
      (s_fault && !word_kill) ##1 !word_kill |=> drive_status_word_o[BIT_TRIP];
   endproperty
   a_fault_trip: assert property (p_fault_trip) else $error("trip bit missing");

   property p_ready_trip;
      @(posedge core_clk_i) disable iff (rst_i)
      trip_reg |=> !drive_status_word_o[BIT_CTRL_READY];
   endproperty
   a_ready_trip: assert property (p_ready_trip) else $error("ready while tripped");

   property p_triplock;
      @(posedge core_clk_i) disable iff (rst_i)
      drive_status_word_o[BIT_TRIPLOCK] |-> drive_status_word_o[BIT_TRIP];
   endproperty
   a_triplock: assert property (p_triplock) else $error("triplock without trip");

   property p_bus_ctrl;
      @(posedge core_clk_i) disable iff (rst_i)
      (s_local_stop || s_local_site) |=> !drive_status_word_o[BIT_BUS_CTRL];
   endproperty
   a_bus_ctrl: assert property (p_bus_ctrl) else $error("bus control while local");

   property p_freq_word;
      @(posedge core_clk_i) disable iff (rst_i)
      ##1 actual_output_frequency_value_o == $past(freq_reg);
   endproperty
   a_freq_word: assert property (p_freq_word) else $error("frequency word stale");

   property p_voltage;
      @(posedge core_clk_i) disable iff (rst_i)
      (!word_kill && (s_volt_low || s_volt_high)) |=> drive_status_word_o[BIT_VOLTAGE_EXC];
   endproperty
   a_voltage: assert property (p_voltage) else $error("voltage bit missing");

   property p_drive_ready;
      @(posedge core_clk_i) disable iff (rst_i)
      !word_kill |=> (drive_status_word_o[BIT_DRIVE_READY] == $past(s_drive_ready));
   endproperty
   a_drive_ready: assert property (p_drive_ready) else $error("drive ready bit wrong");

   property p_enable;
      @(posedge core_clk_i) disable iff (rst_i)
      !word_kill |=> (drive_status_word_o[BIT_ENABLE] == !$past(s_coast));
   endproperty
   a_enable: assert property (p_enable) else $error("enable bit wrong");

   property p_triplock_set;
      @(posedge core_clk_i) disable iff (rst_i)
      (!word_kill && trip_reg && s_locked) |=> drive_status_word_o[BIT_TRIPLOCK];
   endproperty
   a_triplock_set: assert property (p_triplock_set) else $error("triplock bit missing");

   property p_warning;
      @(posedge core_clk_i) disable iff (rst_i)
      !word_kill |=> (drive_status_word_o[BIT_WARNING] == $past(s_warning));
   endproperty
   a_warning: assert property (p_warning) else $error("warning bit wrong");

   property p_speed_eq;
      @(posedge core_clk_i) disable iff (rst_i)
      !word_kill |=> (drive_status_word_o[BIT_SPEED_EQ] == ($past(freq_reg) == $past(ref_reg)));
   endproperty
   a_speed_eq: assert property (p_speed_eq) else $error("speed match bit wrong");

   property p_freq_limit;
      @(posedge core_clk_i) disable iff (rst_i)
      ((freq_abs == lo_reg) || (freq_abs == hi_reg)) |=> !drive_status_word_o[BIT_FREQ_OK];
   endproperty
   a_freq_limit: assert property (p_freq_limit) else $error("frequency ok at a limit");

   property p_in_operation;
      @(posedge core_clk_i) disable iff (rst_i)
      (!word_kill && s_start) |=> drive_status_word_o[BIT_IN_OPERATION];
   endproperty
   a_in_operation: assert property (p_in_operation) else $error("operation bit missing");

   property p_overtemp;
      @(posedge core_clk_i) disable iff (rst_i)
      (!word_kill && s_overtemp && !trip_reg) |=> drive_status_word_o[BIT_OVERTEMP_STOP];
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemperature bit missing");

   property p_torque;
      @(posedge core_clk_i) disable iff (rst_i)
      !word_kill |=> (drive_status_word_o[BIT_TORQUE_EXC] == $past(s_cur_over));
   endproperty
   a_torque: assert property (p_torque) else $error("torque bit wrong");

   property p_timer;
      @(posedge core_clk_i) disable iff (rst_i)
      !word_kill |=> (drive_status_word_o[BIT_TIMER_EXC] == $past(s_timer_over));
   endproperty
   a_timer: assert property (p_timer) else $error("timer bit wrong");

   c_trip_reset: cover property (@(posedge core_clk_i) disable iff (rst_i) trip_reg ##1 !trip_reg);
   c_kill:       cover property (@(posedge core_clk_i) disable iff (rst_i) word_kill);
   c_speed_eq:   cover property (@(posedge core_clk_i) disable iff (rst_i) drive_status_word_o[BIT_SPEED_EQ]);
   c_freq_ok:    cover property (@(posedge core_clk_i) disable iff (rst_i) drive_status_word_o[BIT_FREQ_OK]);
   c_triplock:   cover property (@(posedge core_clk_i) disable iff (rst_i) drive_status_word_o[BIT_TRIPLOCK]);
endmodule : dsw_encoder

// *** verif/dsw_master_model.sv ***
// bus master model: encodes percent references and reads the status word
module dsw_master_model (
   input  wire logic        core_clk_i,
   input  wire logic signed [31:0] pct_i,
   input  wire logic [15:0] drive_status_word_i,
   output logic      [15:0] speed_ref_o,
   output logic      [15:0] seen_word_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // full scale 16'h4000, negatives in two's complement
   assign speed_ref_o = 16'((pct_i * 16384) / 100);
   always_ff @(posedge core_clk_i) begin
      seen_word_o <= drive_status_word_i;
   end
endmodule : dsw_master_model

// *** verif/tb_top.sv ***
// self-checking bench for the drive status word encoder
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top
   import dsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] LO = 16'h0400;
   localparam logic [15:0] HI = 16'h3000;
   logic        core_clk_i = 1'b0;
   logic        rst_i      = 1'b1;
   logic [17:0] cond       = 18'h00000;
   logic [15:0] freq       = 16'h0000;
   int          pct        = 25;
   logic        exp_trip   = 1'b0;
   int          fail_count = 0;
   int          check_count = 0;
   logic [15:0] fv [5]     = '{16'h0400, 16'h0401, 16'h2FFF, 16'h3000, 16'hFBFF};
   wire  [15:0] word;
   wire  [15:0] fval;
   wire  [15:0] sref;
   wire  [15:0] seen;
   wire         tripped;
   ////////////////////////////////////////////////////////////////////////////
   dsw_encoder dut_u (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .ctrl_ready_i(cond[0]), .drive_ready_i(cond[1]),
      .coast_i(cond[2]), .fault_trip_i(cond[3]), .trip_reset_i(cond[4]), .error_no_trip_i(cond[5]),
      .trip_locked_i(cond[6]), .warning_i(cond[7]), .local_stop_i(cond[8]), .local_site_i(cond[9]),
      .start_i(cond[10]), .overtemp_stop_i(cond[11]), .dc_volt_low_i(cond[12]), .dc_volt_high_i(cond[13]),
      .current_over_limit_i(cond[14]), .timer_over_full_i(cond[15]), .link_lost_i(cond[16]),
      .comm_fault_i(cond[17]), .speed_ref_i(sref), .out_freq_i(freq), .freq_low_limit_i(LO),
      .freq_high_limit_i(HI), .drive_status_word_o(word), .actual_output_frequency_value_o(fval),
      .tripped_o(tripped));
   dsw_master_model master_u (
      .core_clk_i(core_clk_i), .pct_i(pct), .drive_status_word_i(word), .speed_ref_o(sref),
      .seen_word_o(seen));
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] exp_word(logic [17:0] c, logic t, logic [15:0] f, logic [15:0] s);
      logic [15:0] a;
      a = f[15] ? -f : f;
      if (c[16] | c[17]) begin
         return 16'h0000;
      end
      return {c[15], c[14], c[12] | c[13], c[11] & !t, c[10] | (f != 16'h0000), (a > LO) && (a < HI),
              !(c[8] | c[9]), s == f, c[7], c[6] & t, 1'b0, c[5] & !t, t, !c[2], c[1], c[0] & !t};
   endfunction : exp_word
   // trip model: set wins, cleared only on a reset rising edge
   task automatic step(input logic [17:0] c, input logic [15:0] f);
      @(posedge core_clk_i);
      #1;
      if (c[3]) begin
         exp_trip = 1'b1;
      end else if (c[4] && !cond[4]) begin
         exp_trip = 1'b0;
      end
      cond = c;
      freq = f;
      // words need four edges to sync and agree, then one to the word, one to the master copy
      repeat (6) @(posedge core_clk_i);
      #1;
   endtask : step
   task automatic check_all;
      `CHK("status word", exp_word(cond, exp_trip, freq, sref), word)
      `CHK("trip state", exp_trip, tripped)
      `CHK("freq word", freq, fval)
      `CHK("master copy", exp_word(cond, exp_trip, freq, sref), seen)
   endtask : check_all
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      fail_count++;
      results();
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      #1;
      `CHK("word in reset", DSW_RESET, word)
      rst_i = 1'b0;
      step(18'h00000, 16'h0000);
      check_all();
      for (int i = 0; i < 18; i++) begin
         if (i != 3 && i != 4 && i != 6) begin
            step(18'h00001 << i, 16'h0000);
            check_all();
         end
      end
      step(18'h1FFA7, 16'h0800);
      check_all();
      step(18'h2FFA7, 16'h0800);
      check_all();
      // trip with masked bits on, then held after the fault drops
      step(18'h00829, 16'h0000);
      check_all();
      step(18'h00861, 16'h0000);
      check_all();
      step(18'h00018, 16'h0000);
      check_all();
      step(18'h00000, 16'h0000);
      step(18'h00050, 16'h0000);
      check_all();
      foreach (fv[k]) begin
         step(18'h00400, fv[k]);
         check_all();
      end
      pct = 100;
      #1;
      `CHK("full scale ref", DSW_FULL_SCALE, sref)
      step(18'h00400, sref);
      check_all();
      pct = 50;
      #1;
      `CHK("half scale ref", 16'h2000, sref)
      step(18'h00400, sref);
      check_all();
      pct = -100;
      #1;
      `CHK("negative full ref", 16'hC000, sref)
      step(18'h00400, sref);
      check_all();
      step(18'h00400, 16'h1000);
      check_all();
      results();
   end
endmodule : tb_top
